// [hdl/ism_slave.sv]
`timescale 1ns/1ns
module ism_slave
  import ism_pkg::*;
#(
  parameter logic [3:0] TYPE_CODE = 4'h5  // Arbitrary value
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic        strapAddrBit2,
  input  wire logic        strapAddrBit1,
  input  wire logic        strapAddrBit0,
  input  wire logic        wpIn,
  output logic             selected,
  output logic [ADDR_W-1:0] addrPtr
);

  logic [SYNC_W-1:0] pinRaw;
  logic [SYNC_W-1:0] syncA_q;
  logic [SYNC_W-1:0] syncB_q;
  logic              sclPrev_q;
  logic              sdaPrev_q;
  logic              sclS;
  logic              sdaS;
  logic              wpS;
  logic [2:0]        strapS;
  logic              sclRise;
  logic              sclFall;
  logic              startDet;
  logic              stopDet;
  ismState_e         state_q;
  logic [3:0]        bitCnt_q;
  logic [7:0]        rxSh_q;
  logic [7:0]        txSh_q;
  logic [7:0]        rdByte_q;
  logic [7:0]        hiByte_q;
  logic [15:0]       ptr_q;
  logic              rw_q;
  logic              mAck_q;
  logic              sdaOe_q;
  logic              fetchGo_q;
  logic              byteDone;
  logic              devDone;
  logic              addrMatch;
  logic              inRx;
  logic              pushReq;
  logic              ackWrite;
  logic              fifoInReady;
  logic              drainValid;
  logic              drainReady;
  logic              drainFire;
  ismWrEntry_s       pushEntry;
  ismWrEntry_s       drainEntry;
  logic [7:0]        memQ [2**ADDR_W];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  assign pinRaw = {strapAddrBit2, strapAddrBit1, strapAddrBit0, wpIn, sdaIn, sclIn};

  for (genvar i = 0; i < SYNC_W; i++) begin : gSync
    always_ff @(posedge clock) begin
      if (!rstn) begin
        syncA_q[i] <= SYNC_RESET[i];
        syncB_q[i] <= SYNC_RESET[i];
      end else begin
        syncA_q[i] <= pinRaw[i];
        syncB_q[i] <= syncA_q[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      sclPrev_q <= SYNC_RESET[SCL_IDX];
      sdaPrev_q <= SYNC_RESET[SDA_IDX];
    end else begin
      sclPrev_q <= sclS;
      sdaPrev_q <= sdaS;
    end
  end

  assign sclS     = syncB_q[SCL_IDX];
  assign sdaS     = syncB_q[SDA_IDX];
  assign wpS      = syncB_q[WP_IDX];
  assign strapS   = syncB_q[STRAP_IDX+2:STRAP_IDX];
  assign sclRise  = sclS && !sclPrev_q;
  assign sclFall  = !sclS && sclPrev_q;
  assign startDet = sclS && sclPrev_q && sdaPrev_q && !sdaS;
  assign stopDet  = sclS && sclPrev_q && !sdaPrev_q && sdaS;

  ////////////////////////////////////////////////////////////////////////////
  // Byte decode
  assign byteDone  = sclFall && (bitCnt_q == BITS_PER_BYTE);
  assign devDone   = (state_q == ST_DEV) && byteDone;
  assign addrMatch = (rxSh_q[7:4] == TYPE_CODE) && (rxSh_q[3:1] == strapS);
  assign inRx      = (state_q == ST_DEV) || (state_q == ST_ADDR_HI) ||
                     (state_q == ST_ADDR_LO) || (state_q == ST_WRITE);
  assign ackWrite  = wpS || fifoInReady;
  assign pushReq   = (state_q == ST_WRITE) && byteDone && !wpS;
  assign pushEntry = '{addr: ptr_q, data: rxSh_q};

  ////////////////////////////////////////////////////////////////////////////
  // Transaction sequencer
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_q  <= ST_IDLE;
      bitCnt_q <= '0;
    end else if (stopDet) begin
      state_q  <= ST_IDLE;
    end else if (startDet) begin
      state_q  <= ST_DEV;
      bitCnt_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
        end
        ST_DEV, ST_ADDR_HI, ST_ADDR_LO, ST_WRITE: begin
          if (sclRise) begin
            bitCnt_q <= bitCnt_q + 1'b1;
          end else if (byteDone) begin
            case (state_q)
              ST_DEV:     state_q <= addrMatch ? ST_DEV_ACK : ST_IDLE;
              ST_ADDR_HI: state_q <= ST_HI_ACK;
              ST_ADDR_LO: state_q <= ST_LO_ACK;
              default:    state_q <= ackWrite ? ST_WR_ACK : ST_IDLE;
            endcase
          end
        end
        ST_DEV_ACK: begin
          if (sclFall) begin
            state_q  <= rw_q ? ST_READ : ST_ADDR_HI;
            bitCnt_q <= rw_q ? FIRST_TX_BIT : '0;
          end
        end
        ST_HI_ACK: begin
          if (sclFall) begin
            state_q  <= ST_ADDR_LO;
            bitCnt_q <= '0;
          end
        end
        ST_LO_ACK, ST_WR_ACK: begin
          if (sclFall) begin
            state_q  <= ST_WRITE;
            bitCnt_q <= '0;
          end
        end
        ST_READ: begin
          if (sclFall) begin
            if (bitCnt_q == BITS_PER_BYTE) begin
              state_q <= ST_RD_ACK;
            end else begin
              bitCnt_q <= bitCnt_q + 1'b1;
            end
          end
        end
        ST_RD_ACK: begin
          if (sclFall) begin
            state_q  <= mAck_q ? ST_READ : ST_IDLE;
            bitCnt_q <= FIRST_TX_BIT;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive shifter and captured fields
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rxSh_q <= BYTE_RESET;
    end else if (sclRise && inRx) begin
      rxSh_q <= {rxSh_q[6:0], sdaS};
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rw_q <= 1'b0;
    end else if (devDone && addrMatch) begin
      rw_q <= rxSh_q[0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      hiByte_q <= BYTE_RESET;
    end else if ((state_q == ST_ADDR_HI) && byteDone) begin
      hiByte_q <= rxSh_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      mAck_q <= 1'b0;
    end else if ((state_q == ST_RD_ACK) && sclRise) begin
      mAck_q <= !sdaS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data line drive
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sdaOe_q <= 1'b0;
    end else if (stopDet || startDet) begin
      sdaOe_q <= 1'b0;
    end else if (sclFall) begin
      case (state_q)
        ST_DEV:     sdaOe_q <= byteDone && addrMatch;
        ST_ADDR_HI: sdaOe_q <= byteDone;
        ST_ADDR_LO: sdaOe_q <= byteDone;
        ST_WRITE:   sdaOe_q <= byteDone && ackWrite;
        ST_DEV_ACK: sdaOe_q <= rw_q && !rdByte_q[7];
        ST_RD_ACK:  sdaOe_q <= mAck_q && !rdByte_q[7];
        ST_READ:    sdaOe_q <= (bitCnt_q != BITS_PER_BYTE) && !txSh_q[7];
        default:    sdaOe_q <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      txSh_q <= BYTE_RESET;
    end else if (sclFall) begin
      if ((state_q == ST_DEV_ACK) || (state_q == ST_RD_ACK)) begin
        txSh_q <= {rdByte_q[6:0], 1'b0};
      end else if (state_q == ST_READ) begin
        txSh_q <= {txSh_q[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address pointer and read fetch
  always_ff @(posedge clock) begin
    if (!rstn) begin
      fetchGo_q <= 1'b0;
    end else begin
      fetchGo_q <= (devDone && addrMatch && rxSh_q[0]) ||
                   ((state_q == ST_RD_ACK) && sclRise && !sdaS);
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ptr_q <= PTR_RESET;
    end else if ((state_q == ST_ADDR_LO) && byteDone) begin
      ptr_q <= {hiByte_q, rxSh_q};
    end else if ((state_q == ST_WRITE) && byteDone && ackWrite) begin
      ptr_q <= ptr_q + 1'b1;
    end else if (fetchGo_q) begin
      ptr_q <= ptr_q + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdByte_q <= BYTE_RESET;
    end else if (fetchGo_q) begin
      rdByte_q <= memQ[ptr_q];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write buffer and array
  assign drainReady = !fetchGo_q;
  assign drainFire  = drainValid && drainReady;

  ism_fifo #(
    .WIDTH ($bits(ismWrEntry_s)),
    .DEPTH (FIFO_DEPTH)
  ) uWrFifo (
    .clock    (clock),
    .rstn     (rstn),
    .inValid  (pushReq),
    .inReady  (fifoInReady),
    .inData   (pushEntry),
    .outValid (drainValid),
    .outReady (drainReady),
    .outData  (drainEntry)
  );

  always_ff @(posedge clock) begin
    if (drainFire) begin
      memQ[drainEntry.addr] <= drainEntry.data;
    end
  end

  assign sdaOut   = 1'b0;
  assign sdaOe    = sdaOe_q;
  assign selected = state_q != ST_IDLE;
  assign addrPtr  = ptr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  devNoAck_a: assert property (devDone && !addrMatch |=> state_q == ST_IDLE && !sdaOe_q)
    else $error("mismatched address word not ignored");
  devAck_a: assert property (devDone && addrMatch |=> sdaOe_q && state_q == ST_DEV_ACK)
    else $error("matching address word not acknowledged");
  rwDir_a: assert property (devDone && addrMatch |=> rw_q == $past(rxSh_q[0]))
    else $error("direction bit not captured");
  addrLoad_a: assert property ((state_q == ST_ADDR_LO) && byteDone |=>
                               ptr_q == {hiByte_q, $past(rxSh_q)} && sdaOe_q)
    else $error("memory address not loaded or acknowledged");
  wpBlock_a: assert property (pushReq |-> !wpS)
    else $error("write passed while protected");
  wrCommit_a: assert property (pushReq && fifoInReady |-> ##[1:3] drainFire)
    else $error("written byte not committed in time");
  ptrWrap_a: assert property ((state_q == ST_WRITE) && byteDone && ackWrite &&
                              ptr_q == PTR_LAST |=> ptr_q == PTR_RESET)
    else $error("write pointer did not wrap");
  fetchStep_a: assert property (fetchGo_q |=> ptr_q == $past(ptr_q) + 16'h0001)
    else $error("read pointer did not advance");
  stopIdle_a: assert property (stopDet |=> state_q == ST_IDLE && !sdaOe_q)
    else $error("stop did not abort");
  driveEdge_a: assert property ($changed(sdaOe_q) |-> $past(sclFall || startDet || stopDet))
    else $error("data line changed off the clock fall");
  rdRelease_a: assert property (state_q == ST_RD_ACK |-> !sdaOe_q)
    else $error("data line held during master acknowledge");

  byteWrite_c: cover property (pushReq ##[1:200] stopDet);
  currentRead_c: cover property (devDone && addrMatch && rxSh_q[0]);
  seqRead_c: cover property ((state_q == ST_RD_ACK) && sclFall && mAck_q);
  protWrite_c: cover property ((state_q == ST_WRITE) && byteDone && wpS);

endmodule

// [hdl/ism_pkg.sv]
package ism_pkg;

  localparam int          ADDR_W        = 16;
  localparam int          DATA_W        = 8;
  localparam int          FIFO_DEPTH    = 8;
  localparam int          SYNC_W        = 6;
  localparam int          SCL_IDX       = 0;
  localparam int          SDA_IDX       = 1;
  localparam int          WP_IDX        = 2;
  localparam int          STRAP_IDX     = 3;
  localparam logic [5:0]  SYNC_RESET    = 6'h03;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [3:0]  FIRST_TX_BIT  = 4'h1;
  localparam logic [15:0] PTR_RESET     = 16'h0000;
  localparam logic [15:0] PTR_LAST      = 16'hffff;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_DEV     = 4'h1,
    ST_DEV_ACK = 4'h3,
    ST_ADDR_HI = 4'h2,
    ST_HI_ACK  = 4'h6,
    ST_ADDR_LO = 4'h7,
    ST_LO_ACK  = 4'h5,
    ST_WRITE   = 4'h4,
    ST_WR_ACK  = 4'hc,
    ST_READ    = 4'hd,
    ST_RD_ACK  = 4'hf
  } ismState_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ismWrEntry_s;

endpackage

// [hdl/ism_fifo.sv]
`timescale 1ns/1ns
module ism_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] slotQ [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [CW-1:0]    count_q;
  logic             push;
  logic             pop;

  assign inReady  = count_q != CW'(DEPTH);
  assign outValid = count_q != '0;
  assign outData  = slotQ[rdPtr_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  always_ff @(posedge clock) begin
    if (push) begin
      slotQ[wrPtr_q] <= inData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointers and fill level
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wrPtr_q <= '0;
    end else if (push) begin
      wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdPtr_q <= '0;
    end else if (pop) begin
      rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      count_q <= '0;
    end else if (push && !pop) begin
      count_q <= count_q + 1'b1;
    end else if (pop && !push) begin
      count_q <= count_q - 1'b1;
    end
  end

endmodule

// [bench/ism_master.sv]
`timescale 1ns/1ns
module ism_master (
  input  wire logic       clock,
  input  wire logic       sdaIn,
  output logic            sclOut,
  output logic            sdaLow,
  output logic            rxValid,
  output logic [8:0]      rxWord
);

  ////////////////////////////////////////////////////////////////////////////////
  // Idle bus: clock high, data released
  initial begin
    sclOut  = 1'b1;
    sdaLow  = 1'b0;
    rxValid = 1'b0;
    rxWord  = 9'h000;
  end

  task automatic waitClk(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // One bit: data set while clock low, sampled late in the high phase
  task automatic bitIo(input logic b, output logic r);
    sclOut = 1'b0;
    waitClk(1);
    sdaLow = !b;
    waitClk(3);
    sclOut = 1'b1;
    waitClk(3);
    r = sdaIn;
    waitClk(1);
  endtask

  task automatic start();
    sclOut = 1'b0;
    waitClk(1);
    sdaLow = 1'b0;
    waitClk(5);
    sclOut = 1'b1;
    waitClk(2);
    sdaLow = 1'b1;
    waitClk(2);
  endtask

  task automatic stop();
    sclOut = 1'b0;
    waitClk(1);
    sdaLow = 1'b1;
    waitClk(5);
    sclOut = 1'b1;
    waitClk(2);
    sdaLow = 1'b0;
    waitClk(4);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Eight bits MSB first, then the ninth clock; result reported as {ack, byte}
  task automatic byteIo(input logic [7:0] d, input logic mAck);
    logic [8:0] w;
    logic       r;
    for (int i = 7; i >= 0; i--) begin
      bitIo(d[i], r);
      w[i] = r;
    end
    bitIo(!mAck, r);
    w[8]    = !r;
    rxWord  = w;
    rxValid = 1'b1;
    waitClk(1);
    rxValid = 1'b0;
  endtask

endmodule

// [bench/ism_slave_tb.sv]
`timescale 1ns/1ns
module ism_slave_tb
  import ism_pkg::*;
;

  localparam logic [3:0] typeCode = 4'h5;  // Arbitrary value

  logic              clock, rstn, sclOut, sdaLow, sdaOut, sdaOe, sdaWire, wpIn;
  logic              selected, rxValid, r;
  logic [2:0]        strap;
  logic [7:0]        w;
  logic [8:0]        rxWord;
  logic [ADDR_W-1:0] addrPtr, expPtr, a0;
  logic [8:0]        expQ[$];
  logic [7:0]        model[logic [15:0]];
  int                miscompares = 0;
  int                compares = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, wire with pull-up, instances
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  assign sdaWire = !(sdaOe && !sdaOut) && !sdaLow;

  ism_slave #(.TYPE_CODE(typeCode)) i_dut (
    .clock(clock), .rstn(rstn), .sclIn(sclOut), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .strapAddrBit2(strap[2]), .strapAddrBit1(strap[1]),
    .strapAddrBit0(strap[0]), .wpIn(wpIn), .selected(selected), .addrPtr(addrPtr));

  ism_master i_master (.clock(clock), .sdaIn(sdaWire), .sclOut(sclOut), .sdaLow(sdaLow),
                       .rxValid(rxValid), .rxWord(rxWord));

  ////////////////////////////////////////////////////////////////////////////////
  // Checking and reporting
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    if (rxValid === 1'b1) begin
      chk(rxWord, expQ.size() ? expQ.pop_front() : 'x);
    end
  end

  initial begin
    repeat (60000) @(posedge clock);
    miscompares++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus sequences
  task automatic xfer(input logic [7:0] d, input logic mAck, input logic [8:0] exp);
    expQ.push_back(exp);
    i_master.byteIo(d, mAck);
  endtask

  function automatic logic [7:0] devWord(input logic rw);
    return {typeCode, strap, rw};
  endfunction

  task automatic wrHdr(input logic [15:0] a);
    i_master.start();
    xfer(devWord(1'b0), 1'b0, {1'b1, devWord(1'b0)});
    xfer(a[15:8], 1'b0, {1'b1, a[15:8]});
    xfer(a[7:0], 1'b0, {1'b1, a[7:0]});
    expPtr = a;
  endtask

  task automatic wrBurst(input logic [15:0] a, input int n);
    logic [7:0] d;
    wrHdr(a);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      xfer(d, 1'b0, {1'b1, d});
      if (!wpIn) model[expPtr] = d;
      expPtr++;
    end
    i_master.stop();
    chk(addrPtr, expPtr);
  endtask

  task automatic rdBurst(input logic useAddr, input logic [15:0] a, input int n);
    if (useAddr) wrHdr(a);
    i_master.start();
    xfer(devWord(1'b1), 1'b0, {1'b1, devWord(1'b1)});
    for (int i = 0; i < n; i++) begin
      xfer(8'hff, i < n - 1, {i < n - 1, model[expPtr]});
      expPtr++;
    end
    i_master.stop();
    chk(addrPtr, expPtr);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rstn      = 1'b0;
    wpIn      = 1'b0;
    void'($urandom(32'h4dc5));
    strap = 3'($urandom);
    repeat (8) @(posedge clock);
    #2;
    rstn = 1'b1;
    i_master.waitClk(3);
    chk({sdaOe, selected, addrPtr}, 32'h0);
    // Wrong type code, then each strap bit flipped
    for (int i = 0; i < 4; i++) begin
      w = (i == 0) ? {4'h3, strap, 1'b0} : {typeCode, strap ^ 3'(1 << (i - 1)), 1'b0};
      i_master.start();
      xfer(w, 1'b0, {1'b0, w});
      xfer(8'h00, 1'b0, 9'h000);
      chk(selected, 1'b0);
      i_master.stop();
    end
    a0 = 16'($urandom);
    wrBurst(a0, 1);
    rdBurst(1'b1, a0, 1);
    wrBurst(16'hfffe, 4);
    rdBurst(1'b1, 16'hffff, 2);
    rdBurst(1'b0, 16'h0000, 1);
    // Protected writes
    wpIn = 1'b1;
    i_master.waitClk(3);
    wrBurst(16'hfffe, 2);
    rdBurst(1'b1, 16'hfffe, 2);
    wpIn = 1'b0;
    i_master.waitClk(3);
    // Stop in the middle of a byte
    i_master.start();
    xfer(devWord(1'b0), 1'b0, {1'b1, devWord(1'b0)});
    for (int i = 0; i < 4; i++) i_master.bitIo(1'b1, r);
    i_master.stop();
    chk(selected, 1'b0);
    rdBurst(1'b0, 16'h0000, 1);
    // Burst longer than the write buffer, read back through the array
    a0 = 16'($urandom);
    wrBurst(a0, FIFO_DEPTH + 2);
    rdBurst(1'b1, a0, FIFO_DEPTH + 2);
    chk({sdaOe, selected, 16'(expQ.size())}, 32'h0);
    test_done();
  end

endmodule
